/* design/fsp_pkg.sv */
// constants shared by the flash self-programming control block
package fsp_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PROG_CTRL = 8'h00;
  localparam logic [7:0] REG_MEM_SIZE = 8'h04;
  localparam logic [7:0] REG_FW_ADDR = 8'h08;
  localparam logic [7:0] REG_WR_DATA = 8'h0c;
  localparam logic [7:0] REG_COMMAND = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RX_PERIOD = 8'h18;
  localparam logic [7:0] REG_RD_DATA = 8'h1c;
  // ----------------------------------------------------------------
  // field positions and command codes
  // ----------------------------------------------------------------
  localparam int CTRL_WDIS_BIT = 0;
  localparam int CTRL_ASRC_BIT = 1;
  localparam int CTRL_MLOW_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_RXVALID_BIT = 3;
  localparam int STAT_ONBOARD_BIT = 4;
  localparam logic [7:0] CMD_PROGRAM = 8'h01;
  localparam logic [7:0] CMD_ERASE = 8'h02;
  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] MEM_SIZE_RESET = 8'hcf;
  localparam logic WDIS_RESET = 1'b1;
  localparam logic [7:0] OP_CYCLES = 8'h08;
  // reset command byte is all zero: start bit plus eight data bits low
  localparam logic [3:0] RESET_CMD_LOW_BITS = 4'h9;
endpackage

/* design/fsp_mem.sv */
// flash array stand-in with registered read data
`timescale 1ns/1ps
`default_nettype none
module fsp_mem #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  // clock
  input wire logic clk_i,
  input wire logic ce_i,
  // access
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule
`default_nettype wire

/* design/fsp_ctrl.sv */
// flash self-programming mode control with wishbone registers
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 8
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // mode and cpu side
  input wire logic onboard_i,
  input wire logic [AW-1:0] cpu_addr_i,
  // programming link
  input wire logic serial_sel_i,
  input wire logic flash_mode_pin_i,
  input wire logic rxd_i,
  // status outputs
  output logic [AW-1:0] flash_addr_o,
  output logic busy_o,
  output logic flash_write_disable_o,
  output logic [7:0] memory_size_select_o,
  output logic rx_clk_valid_o,
  output logic rx_tick_o
);
  typedef enum logic {OP_IDLE, OP_BUSY} fsp_op_e;
  typedef enum logic [2:0] {BD_PIN_LO, BD_PIN_HI, BD_WAIT_START, BD_MEASURE, BD_LOCKED} fsp_bd_e;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic wdis;
    logic asrc;
    logic mlow;
    logic [7:0] msize;
    logic [AW-1:0] fw_addr;
    logic [DW-1:0] wr_data;
    logic refused;
    logic done;
    fsp_op_e op;
    logic [7:0] op_cnt;
    logic [AW-1:0] faddr;
    logic mem_we;
    logic [DW-1:0] mem_wd;
    fsp_bd_e bd;
    logic [3:0] cnt9;
    logic [15:0] lowcnt;
    logic [15:0] period;
    logic valid;
    logic tick;
    logic [15:0] tick_cnt;
  } fsp_state_s;

  fsp_state_s q_r;
  fsp_state_s q_nxt;
  logic [DW-1:0] mem_rdata;

  fsp_mem #(.AW(AW), .DW(DW)) u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(q_r.mem_we),
    .addr_i(q_r.faddr),
    .wdata_i(q_r.mem_wd),
    .rdata_o(mem_rdata)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic cmd_hit;
  logic [31:0] tmp;
  always_comb begin
    q_nxt = q_r;
    tmp = 32'h0;
    req = wb_cyc_i && wb_stb_i && !q_r.ack;
    wr = req && wb_we_i;
    cmd_hit = wr && wb_adr_i == REG_COMMAND && wb_sel_i[0] &&
              (wb_dat_i[7:0] == CMD_PROGRAM || wb_dat_i[7:0] == CMD_ERASE);
    q_nxt.ack = req;
    q_nxt.mem_we = 1'b0;
    q_nxt.tick = 1'b0;
    // register writes
    if (wr && wb_adr_i == REG_PROG_CTRL && wb_sel_i[0]) begin
      q_nxt.wdis = wb_dat_i[CTRL_WDIS_BIT];
      if (!onboard_i) begin
        q_nxt.asrc = wb_dat_i[CTRL_ASRC_BIT];
        q_nxt.mlow = wb_dat_i[CTRL_MLOW_BIT];
      end
    end else if (wr && wb_adr_i == REG_MEM_SIZE && wb_sel_i[0]) begin
      q_nxt.msize = wb_dat_i[7:0];
    end else if (wr && wb_adr_i == REG_FW_ADDR) begin
      tmp = merge(32'(q_r.fw_addr), wb_dat_i, wb_sel_i);
      q_nxt.fw_addr = tmp[AW-1:0];
    end else if (wr && wb_adr_i == REG_WR_DATA) begin
      tmp = merge(32'(q_r.wr_data), wb_dat_i, wb_sel_i);
      q_nxt.wr_data = tmp[DW-1:0];
    end
    // refused and done flags are cleared by writing one; a new event wins
    if (wr && wb_adr_i == REG_STATUS && wb_sel_i[0]) begin
      if (wb_dat_i[STAT_REFUSED_BIT]) q_nxt.refused = 1'b0;
      if (wb_dat_i[STAT_DONE_BIT]) q_nxt.done = 1'b0;
    end
    // effective flash address; on-board mode ignores the source bit
    if (q_r.asrc && !onboard_i) begin
      q_nxt.faddr = q_r.fw_addr;
    end else begin
      q_nxt.faddr = cpu_addr_i;
    end
    // write and erase sequencing
    case (q_r.op)
      OP_IDLE: begin
        if (cmd_hit) begin
          if (q_r.wdis) begin
            q_nxt.refused = 1'b1;
          end else begin
            q_nxt.op = OP_BUSY;
            q_nxt.op_cnt = OP_CYCLES;
            q_nxt.mem_we = 1'b1;
            q_nxt.faddr = q_r.faddr;
            q_nxt.mem_wd = (wb_dat_i[7:0] == CMD_ERASE) ? {DW{1'b1}} : q_r.wr_data;
          end
        end
      end
      OP_BUSY: begin
        // address is held so the array sees a stable location
        q_nxt.faddr = q_r.faddr;
        q_nxt.op_cnt = q_r.op_cnt - 8'h01;
        if (q_r.op_cnt == 8'h01) begin
          q_nxt.op = OP_IDLE;
          q_nxt.done = 1'b1;
        end
      end
      default: q_nxt.op = OP_IDLE;
    endcase
    // receive period measured over the all-low reset command
    case (q_r.bd)
      BD_PIN_LO: begin
        if (flash_mode_pin_i && serial_sel_i) q_nxt.bd = BD_PIN_HI;
      end
      BD_PIN_HI: begin
        if (!flash_mode_pin_i) q_nxt.bd = BD_WAIT_START;
      end
      BD_WAIT_START: begin
        // the edge that sees the start bit already counts as a low cycle
        q_nxt.cnt9 = rxd_i ? 4'h0 : 4'h1;
        q_nxt.lowcnt = 16'h0;
        if (!rxd_i) q_nxt.bd = BD_MEASURE;
      end
      BD_MEASURE: begin
        // dividing on the fly by nine avoids a divider
        if (rxd_i) begin
          q_nxt.period = q_r.lowcnt;
          q_nxt.valid = (q_r.lowcnt != 16'h0);
          q_nxt.tick_cnt = 16'h0;
          q_nxt.bd = (q_r.lowcnt != 16'h0) ? BD_LOCKED : BD_WAIT_START;
        end else if (q_r.cnt9 == RESET_CMD_LOW_BITS - 4'h1) begin
          q_nxt.cnt9 = 4'h0;
          q_nxt.lowcnt = q_r.lowcnt + 16'h1;
        end else begin
          q_nxt.cnt9 = q_r.cnt9 + 4'h1;
        end
      end
      BD_LOCKED: begin
        if (q_r.tick_cnt >= q_r.period - 16'h1) begin
          q_nxt.tick_cnt = 16'h0;
          q_nxt.tick = 1'b1;
        end else begin
          q_nxt.tick_cnt = q_r.tick_cnt + 16'h1;
        end
        // a new mode pulse starts a new session and a new measurement
        if (flash_mode_pin_i || !serial_sel_i) begin
          q_nxt.valid = 1'b0;
          q_nxt.bd = BD_PIN_LO;
        end
      end
      default: q_nxt.bd = BD_PIN_LO;
    endcase
    // read data
    q_nxt.dat = 32'h0;
    if (req && !wb_we_i) begin
      if (wb_adr_i == REG_PROG_CTRL) begin
        q_nxt.dat[CTRL_WDIS_BIT] = q_r.wdis;
        q_nxt.dat[CTRL_ASRC_BIT] = q_r.asrc;
        q_nxt.dat[CTRL_MLOW_BIT] = q_r.mlow;
      end else if (wb_adr_i == REG_MEM_SIZE) begin
        q_nxt.dat[7:0] = q_r.msize;
      end else if (wb_adr_i == REG_FW_ADDR) begin
        q_nxt.dat[AW-1:0] = q_r.fw_addr;
      end else if (wb_adr_i == REG_WR_DATA) begin
        q_nxt.dat[DW-1:0] = q_r.wr_data;
      end else if (wb_adr_i == REG_STATUS) begin
        q_nxt.dat[STAT_BUSY_BIT] = (q_r.op == OP_BUSY);
        q_nxt.dat[STAT_REFUSED_BIT] = q_r.refused;
        q_nxt.dat[STAT_DONE_BIT] = q_r.done;
        q_nxt.dat[STAT_RXVALID_BIT] = q_r.valid;
        q_nxt.dat[STAT_ONBOARD_BIT] = onboard_i;
      end else if (wb_adr_i == REG_RX_PERIOD) begin
        q_nxt.dat[15:0] = q_r.period;
      end else if (wb_adr_i == REG_RD_DATA) begin
        q_nxt.dat[DW-1:0] = mem_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
      q_r.wdis <= WDIS_RESET;
      q_r.msize <= MEM_SIZE_RESET;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  assign wb_dat_o = q_r.dat;
  assign wb_ack_o = q_r.ack;
  assign flash_addr_o = q_r.faddr;
  assign busy_o = (q_r.op == OP_BUSY);
  assign flash_write_disable_o = q_r.wdis;
  assign memory_size_select_o = q_r.msize;
  assign rx_clk_valid_o = q_r.valid;
  assign rx_tick_o = q_r.tick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cmd_write;
    ce_i && cmd_hit;
  endsequence
  sequence s_ctrl_write;
    ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == REG_PROG_CTRL;
  endsequence

  chk_refuse_protected: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cmd_write ##0 (flash_write_disable_o && !busy_o)
      |=> !busy_o && !q_r.mem_we && q_r.refused)
    else $error("command accepted while write disabled");
  chk_start_unprotected: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cmd_write ##0 (!flash_write_disable_o && !busy_o) |=> busy_o && q_r.mem_we)
    else $error("command not started while write enabled");
  chk_onboard_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctrl_write ##0 onboard_i |=> $stable(q_r.asrc) && $stable(q_r.mlow))
    else $error("mode select bits changed in on-board mode");
  chk_addr_cpu_path: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !busy_o && !(q_r.asrc && !onboard_i) && !cmd_hit
      |=> flash_addr_o == $past(cpu_addr_i))
    else $error("flash address not taken from cpu");
  chk_addr_fw_path: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !busy_o && q_r.asrc && !onboard_i && !cmd_hit
      |=> flash_addr_o == $past(q_r.fw_addr))
    else $error("flash address not taken from firmware value");
  chk_size_reset: assert property (@(posedge clk_i)
    rst_i |=> memory_size_select_o == MEM_SIZE_RESET)
    else $error("memory size reset value wrong");
  chk_rx_valid_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(rx_clk_valid_o) |-> $past(q_r.bd == BD_MEASURE) && $past(rxd_i) && serial_sel_i)
    else $error("receive clock valid without measured reset command");
  chk_rx_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_tick_o && q_r.period >= 16'h2 && q_r.bd == BD_LOCKED |=> !rx_tick_o)
    else $error("receive ticks closer than measured period");
  chk_busy_length: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    $rose(busy_o) |-> busy_o [*8] ##1 !busy_o)
    else $error("operation length wrong");
endmodule
`default_nettype wire

/* bench/fsp_prog_model.sv */
// external flash programmer model: mode pin pulse and reset command
`timescale 1ns/1ps
`default_nettype none
module fsp_prog_model (
  // clock
  input wire logic clk_i,
  // programming link
  output logic flash_mode_pin_o,
  output logic rxd_o
);
  initial begin
    flash_mode_pin_o = 1'b0;
    rxd_o = 1'b1;
  end
  // reset command 00h: start bit and eight zero bits, then stop bit
  task automatic reset_cmd(input int bit_cyc);
    @(posedge clk_i);
    flash_mode_pin_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    flash_mode_pin_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (9 * bit_cyc) @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (2 * bit_cyc) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* bench/fsp_ctrl_test.sv */
// self-checking bench for the flash self-programming control block
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_test
  import fsp_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, onb = 0, ssel = 0;
  logic [7:0] adr = 8'h00, mem_m;
  logic [31:0] dat = 32'h0, q, seed = 32'd44, ctrl_m = 32'h1, d;
  logic [15:0] cpu = 16'h0, fa;
  logic [31:0] dat_o;
  logic ack, busy, wdis, rxv, tick, pin, rxd;
  logic [7:0] msz;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hf;
  int n_mismatch = 0, compares = 0, n;
  fsp_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .onboard_i(onb), .cpu_addr_i(cpu), .serial_sel_i(ssel),
    .flash_mode_pin_i(pin), .rxd_i(rxd), .flash_addr_o(fa), .busy_o(busy),
    .flash_write_disable_o(wdis), .memory_size_select_o(msz), .rx_clk_valid_o(rxv),
    .rx_tick_o(tick));
  fsp_prog_model i_prog (.clk_i(clk_i), .flash_mode_pin_o(pin), .rxd_o(rxd));
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask
  // one classic cycle, released only at the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
      k++;
      if (k == 50) begin
        n_mismatch++;
        give_verdict();
      end
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // ctrl model: mode select bits frozen in on-board mode
  task automatic wr_ctrl(input logic [31:0] v);
    ctrl_m = onb ? ((ctrl_m & 32'h6) | (v & 32'h1)) : (v & 32'h7);
    wb(1'b1, REG_PROG_CTRL, v);
    wb(1'b0, REG_PROG_CTRL, 32'h0);
    chk("ctrl", q, ctrl_m);
  endtask
  task automatic op_count(output int c);
    c = 0;
    repeat (20) begin
      @(posedge clk_i);
      if (busy === 1'b1) c++;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("wdis_rst", 32'(wdis), 32'h1);
    chk("size_o", 32'(msz), 32'hcf);
    wb(1'b0, REG_MEM_SIZE, 32'h0);
    chk("size_rst", q, 32'hcf);
    wb(1'b1, REG_MEM_SIZE, 32'h44);
    wb(1'b0, REG_MEM_SIZE, 32'h0);
    chk("size_wr", q, 32'h44);
    // ----------------------------------------------------------------
    // program then erase from firmware address, disable held clear
    // ----------------------------------------------------------------
    wr_ctrl(32'h2);
    d = xs();
    wb(1'b1, REG_FW_ADDR, {16'h0, d[15:0]});
    for (int i = 0; i < 2; i++) begin
      mem_m = (i != 0) ? 8'hff : d[23:16];
      wb(1'b1, REG_WR_DATA, {24'h0, d[23:16]});
      // busy is counted from the edge that takes the command
      fork
        wb(1'b1, REG_COMMAND, {24'h0, (i != 0) ? CMD_ERASE : CMD_PROGRAM});
        op_count(n);
      join
      chk("busy_len", n, 32'(OP_CYCLES));
      chk("faddr_fw", 32'(fa), {16'h0, d[15:0]});
      wb(1'b0, REG_STATUS, 32'h0);
      chk("done", 32'(q[STAT_DONE_BIT]), 32'h1);
      wb(1'b1, REG_STATUS, 32'h6);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("flags_clr", 32'(q[2:1]), 32'h0);
      wb(1'b0, REG_RD_DATA, 32'h0);
      chk("rdata", 32'(q[7:0]), 32'(mem_m));
    end
    // write-disable set: command refused, array untouched
    wr_ctrl(32'h3);
    wb(1'b1, REG_WR_DATA, {24'h0, ~mem_m});
    fork
      wb(1'b1, REG_COMMAND, {24'h0, CMD_PROGRAM});
      op_count(n);
    join
    chk("busy_ref", n, 32'h0);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("refused", 32'(q[STAT_REFUSED_BIT]), 32'h1);
    wb(1'b0, REG_RD_DATA, 32'h0);
    chk("rdata_ref", 32'(q[7:0]), 32'(mem_m));
    // byte lane merge of the firmware address
    d[31:16] = 16'(xs());
    sel <= 4'h2;
    wb(1'b1, REG_FW_ADDR, {16'h0, d[31:16]});
    sel <= 4'hf;
    wb(1'b0, REG_FW_ADDR, 32'h0);
    chk("fw_lane", q, {16'h0, d[31:24], d[7:0]});
    // on-board mode ignores mode bits and source select
    onb <= 1'b1;
    cpu <= 16'(xs());
    @(posedge clk_i);
    wr_ctrl(32'h4);
    chk("faddr_onb", 32'(fa), 32'(cpu));
    wb(1'b0, REG_STATUS, 32'h0);
    chk("onb_stat", 32'(q[STAT_ONBOARD_BIT]), 32'h1);
    onb <= 1'b0;
    @(posedge clk_i);
    wr_ctrl(32'h1);
    cpu <= 16'(xs());
    repeat (3) @(posedge clk_i);
    chk("faddr_cpu", 32'(fa), 32'(cpu));
    // clock enable low freezes the address register
    d[15:0] = cpu;
    ce <= 1'b0;
    cpu <= 16'(xs());
    repeat (3) @(posedge clk_i);
    chk("ce_hold", 32'(fa), 32'(d[15:0]));
    ce <= 1'b1;
    // receive period from the programmer reset command
    ssel <= 1'b1;
    i_prog.reset_cmd(5);
    wb(1'b0, REG_RX_PERIOD, 32'h0);
    chk("period", q, 32'h5);
    chk("rx_valid", 32'(rxv), 32'h1);
    n = 0;
    repeat (20) begin
      @(posedge clk_i);
      if (tick === 1'b1) n++;
    end
    chk("ticks", n, 32'h4);
    // reset in mid-run restores protection and the prohibited size
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("wdis_rst2", 32'(wdis), 32'h1);
    chk("size_rst2", 32'(msz), 32'hcf);
    chk("rxv_rst2", 32'(rxv), 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
